// File: dps_defs.svh
// timing counts and field constants for the dual-port memory host port
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
`define DPS_CLK_PERIOD_NS       5
// least times in ns, rounded up to cycles
`define DPS_READ_CYCLE_NS       20
`define DPS_READ_CYC            ((`DPS_READ_CYCLE_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_WRITE_PULSE_NS      15
`define DPS_HZWE_NS             12
`define DPS_DATA_SETUP_NS       15
`define DPS_WPULSE_OE_NS        (`DPS_HZWE_NS + `DPS_DATA_SETUP_NS)
`define DPS_WPULSE_CYC          ((`DPS_WRITE_PULSE_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_WPULSE_OE_CYC       ((`DPS_WPULSE_OE_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_HZWE_CYC            ((`DPS_HZWE_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_TOKEN_W2R_NS        5
`define DPS_TOKEN_W2R_CYC       ((`DPS_TOKEN_W2R_NS + `DPS_CLK_PERIOD_NS - 1) / `DPS_CLK_PERIOD_NS)
`define DPS_SETUP_CYC           1
`define DPS_TOKEN_GRANT_BIT     0
`endif

// File: dps_pkg.sv
// types for the dual-port memory host port
package dps_pkg;
    typedef enum logic [2:0] {
        DPS_IDLE   = 3'b000,
        DPS_SETUP  = 3'b001,
        DPS_READ   = 3'b010,
        DPS_WRITE  = 3'b011,
        DPS_END    = 3'b100,
        DPS_GAP    = 3'b101,
        DPS_TREAD  = 3'b110
    } dps_state_t;
    typedef enum logic [1:0] {
        DPS_OP_READ   = 2'b00,
        DPS_OP_WRITE  = 2'b01,
        DPS_OP_TOKEN  = 2'b10
    } dps_op_t;
endpackage : dps_pkg

// File: dps_host.sv
// host controller driving one port of the asynchronous dual-port memory
`timescale 1ns/100ps
`default_nettype none
`include "dps_defs.svh"
// Operation
// - keep write strobe high through every read
// - token reads always strobed with token select, never address-only
// - address set up before chip select falls
// - array uses chip select low; token uses token select low, held whole strobe
// - write strobe high whenever address changes
// - lengthen write pulse when output enable stays low
// - never drive data while device may drive it
// - chip select stays high through token write and read back
module dps_host #(
    parameter int ADDR_W = 14,
    parameter int DATA_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             reqValid,
    output logic                  reqReady,
    input  wire dps_pkg::dps_op_t reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWData,
    input  wire logic [1:0]       reqByteEn,
    input  wire logic             reqKeepOe,
    output logic                  rspValid,
    output logic [DATA_W-1:0]     rspRData,
    output logic                  rspGranted,
    output logic [ADDR_W-1:0]     memAddr,
    output logic                  memChipSel_n,
    output logic                  memTokenSel_n,
    output logic                  memWrite_n,
    output logic                  memOutEn_n,
    output logic                  memHighByteSel_n,
    output logic                  memLowByteSel_n,
    input  wire logic [DATA_W-1:0] memDataIn,
    output logic [DATA_W-1:0]     memDataOut,
    output logic                  memDataOe,
    input  wire logic             memBusy_n
);
    import dps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    dps_state_t  state_reg, state_next;
    dps_op_t     op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [1:0]  be_reg;
    logic        keepOe_reg, granted_reg, rspValid_reg;
    logic [7:0]  cnt_reg, cnt_next;
    logic [DATA_W-1:0] dataSync1_reg, dataSync2_reg;
    logic        busySync1_reg, busySync2_reg;

    // pins sampled through two flops
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            dataSync1_reg <= '0;
            dataSync2_reg <= '0;
            busySync1_reg <= 1'b1;
            busySync2_reg <= 1'b1;
        end else begin
            dataSync1_reg <= memDataIn;
            dataSync2_reg <= dataSync1_reg;
            busySync1_reg <= memBusy_n;
            busySync2_reg <= busySync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire isToken   = (op_reg == DPS_OP_TOKEN);
    wire isWrite   = (op_reg != DPS_OP_READ);
    wire busyHold  = ~busySync2_reg;
    wire [7:0] readCyc   = 8'(`DPS_READ_CYC + 2);
    wire [7:0] pulseCyc  = keepOe_reg ? 8'(`DPS_WPULSE_OE_CYC) : 8'(`DPS_WPULSE_CYC);
    wire [7:0] gapCyc    = 8'(`DPS_TOKEN_W2R_CYC);
    wire       cntDone   = (cnt_reg == 8'h00);
    wire       inWrite   = (state_reg == DPS_WRITE);
    wire       inRead    = (state_reg == DPS_READ) || (state_reg == DPS_TREAD);
    wire       selActive = inWrite || inRead;
    // drive data only once device output turn-off time passed
    wire       hzDone    = ~keepOe_reg || (cnt_reg <= pulseCyc - 8'(`DPS_HZWE_CYC));

    assign reqReady = (state_reg == DPS_IDLE);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cntDone ? 8'h00 : cnt_reg - 8'h01;
        case (state_reg)
            DPS_IDLE: begin
                if (reqValid) begin
                    state_next = DPS_SETUP;
                    cnt_next   = 8'(`DPS_SETUP_CYC);
                end
            end
            DPS_SETUP: begin
                if (cntDone) begin
                    if (isWrite) begin
                        if (!busyHold) begin
                            state_next = DPS_WRITE;
                            cnt_next   = pulseCyc;
                        end
                    end else begin
                        state_next = DPS_READ;
                        cnt_next   = readCyc;
                    end
                end
            end
            DPS_WRITE: begin
                if (cntDone) begin
                    state_next = DPS_END;
                end
            end
            DPS_END: begin
                if (isToken) begin
                    state_next = DPS_GAP;
                    cnt_next   = gapCyc;
                end else begin
                    state_next = DPS_IDLE;
                end
            end
            DPS_GAP: begin
                if (cntDone) begin
                    state_next = DPS_TREAD;
                    cnt_next   = readCyc;
                end
            end
            DPS_READ, DPS_TREAD: begin
                if (cntDone) begin
                    state_next = DPS_IDLE;
                end
            end
            default: begin
                state_next = DPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= DPS_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            op_reg     <= DPS_OP_READ;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            be_reg     <= 2'b00;
            keepOe_reg <= 1'b0;
        end else if (reqValid && reqReady) begin
            op_reg     <= reqOp;
            addr_reg   <= reqAddr;
            wdata_reg  <= (reqOp == DPS_OP_TOKEN) ? {DATA_W{1'b1}} ^ DATA_W'(1) : reqWData;
            be_reg     <= (reqOp == DPS_OP_TOKEN) ? 2'b11 : reqByteEn;
            keepOe_reg <= reqKeepOe;
        end
    end

    // capture read data at the end of the access
    wire readEnd = inRead && cntDone;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_reg    <= '0;
            granted_reg  <= 1'b0;
            rspValid_reg <= 1'b0;
        end else begin
            rspValid_reg <= readEnd || (state_reg == DPS_END && op_reg == DPS_OP_WRITE);
            if (readEnd) begin
                rdata_reg   <= dataSync2_reg;
                granted_reg <= isToken && ~dataSync2_reg[`DPS_TOKEN_GRANT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign rspValid         = rspValid_reg;
    assign rspRData         = rdata_reg;
    assign rspGranted       = granted_reg;
    assign memAddr          = addr_reg;
    assign memChipSel_n     = ~(selActive && !isToken);
    assign memTokenSel_n    = ~(selActive && isToken);
    assign memWrite_n       = ~inWrite;
    assign memOutEn_n       = ~(inRead || (inWrite && keepOe_reg));
    assign memHighByteSel_n = ~(selActive && (inRead || be_reg[1]));
    assign memLowByteSel_n  = ~(selActive && (inRead || be_reg[0]));
    assign memDataOut       = wdata_reg;
    assign memDataOe        = inWrite && hzDone;
endmodule : dps_host
`default_nettype wire

// File: dps_mem_model.sv
// behavioural model of one port of the dual-port memory
`timescale 1ns/100ps
`default_nettype none
module dps_mem_model (
    input  wire logic [13:0] memAddr,
    input  wire logic        memChipSel_n,
    input  wire logic        memTokenSel_n,
    input  wire logic        memWrite_n,
    input  wire logic        memOutEn_n,
    input  wire logic        memHighByteSel_n,
    input  wire logic        memLowByteSel_n,
    input  wire logic [15:0] memDataOut,
    input  wire logic        memDataOe,
    input  wire logic        otherHold,
    input  wire logic        busyHold,
    output logic      [15:0] memDataIn,
    output logic             memBusy_n,
    output logic             mailFlag
);
    logic [15:0] mem [0:16383];
    logic [7:0]  own = 8'h00;
    logic [15:0] wd;
    logic [13:0] wa;
    logic        wc, wh, wl;
    wire selAny = !memChipSel_n || !memTokenSel_n;
    wire wrOn = !memWrite_n && selAny && (!memHighByteSel_n || !memLowByteSel_n);
    wire rdOn = !memOutEn_n && memWrite_n && selAny;
    wire [15:0] rdVal = !memChipSel_n ? mem[memAddr] : {15'h7fff, !own[memAddr[2:0]]};
    // released data lines show the inverted read value, not the last value
    assign memDataIn = memDataOe ? memDataOut : rdOn ? rdVal : ~rdVal;
    assign memBusy_n = !busyHold;
    // mailbox flag timed from the later of select and write strobe
    wire mailHit = !memChipSel_n && !memWrite_n && (memAddr == 14'h3fff);
    initial mailFlag = 1'b0;
    always @(posedge mailHit) mailFlag = 1'b1;
    always @* if (wrOn) begin
        wd = memDataOut;
        wa = memAddr;
        wc = !memChipSel_n;
        wh = !memHighByteSel_n;
        wl = !memLowByteSel_n;
    end
    always @(negedge wrOn) begin
        if (wc) begin
            if (wh) mem[wa][15:8] = wd[15:8];
            if (wl) mem[wa][7:0] = wd[7:0];
        end else own[wa[2:0]] = !wd[0] && !otherHold;
    end
endmodule : dps_mem_model
`default_nettype wire

// File: dps_host_sva.sv
// protocol assertions on the host side pins
`timescale 1ns/100ps
`default_nettype none
module dps_host_sva
    import dps_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire dps_op_t     reqOp,
    input wire logic [13:0] memAddr,
    input wire logic        memChipSel_n,
    input wire logic        memTokenSel_n,
    input wire logic        memWrite_n,
    input wire logic        memOutEn_n,
    input wire logic [15:0] memDataOut,
    input wire logic        memDataOe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence sRdTake; reqValid && reqReady && reqOp == DPS_OP_READ; endsequence
    sequence sWrStart; $fell(memWrite_n); endsequence
    chk_read_no_write: assert property (sRdTake |=> memWrite_n [*8])
        else $error("write strobe low in read");
    chk_addr_before_cs: assert property ($fell(memChipSel_n) |-> $stable(memAddr))
        else $error("address moved at select");
    chk_one_select: assert property (!memWrite_n |-> memChipSel_n ^ memTokenSel_n)
        else $error("bad select pair");
    chk_addr_we_high: assert property (!$stable(memAddr) |-> memWrite_n && $past(memWrite_n))
        else $error("address moved in write");
    chk_pulse_min: assert property (sWrStart |-> !memWrite_n [*3])
        else $error("write pulse short");
    chk_pulse_oe: assert property (sWrStart ##0 !memOutEn_n |-> !memWrite_n [*6])
        else $error("write pulse short with oe");
    chk_no_contention: assert property (!memOutEn_n && memWrite_n && !(memChipSel_n
        && memTokenSel_n) |-> !memDataOe)
        else $error("data driven in read");
    chk_token_cs_high: assert property (!memTokenSel_n |-> memChipSel_n)
        else $error("select low in token access");
    chk_token_bit0: assert property (!memTokenSel_n && !memWrite_n |-> memDataOe
        && !memDataOut[0])
        else $error("token request bit not low");
endmodule : dps_host_sva
bind dps_host dps_host_sva u_sva (.*);
`default_nettype wire

// File: dps_host_test.sv
// self-checking bench for the host port controller
`timescale 1ns/100ps
`default_nettype none
module dps_host_test;
    import dps_pkg::*;
    logic sys_clk = 0, reset = 1, reqValid = 0, reqKeepOe = 0, otherHold = 0, busyHold = 0;
    dps_op_t reqOp = DPS_OP_READ;
    logic [13:0] reqAddr = '0, memAddr;
    logic [15:0] reqWData = '0, rspRData, memDataOut, memDataIn;
    logic [1:0]  reqByteEn = '0;
    logic reqReady, rspValid, rspGranted, memChipSel_n, memTokenSel_n, memWrite_n;
    logic memOutEn_n, memHighByteSel_n, memLowByteSel_n, memDataOe, memBusy_n, mailFlag;
    int fail_count = 0, checks_done = 0, cyc = 0, nWr = 0, n;
    dps_host dut (.*);
    dps_mem_model u_mem (.*);
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(negedge memWrite_n) nWr++;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic access(input dps_op_t op, input logic [13:0] a, input logic [15:0] d,
                          input logic [1:0] be, input logic k);
        @(negedge sys_clk);
        while (reqReady !== 1'b1) @(negedge sys_clk);
        reqValid = 1'b1;
        reqOp = op;
        {reqAddr, reqWData, reqByteEn, reqKeepOe} = {a, d, be, k};
        @(negedge sys_clk);
        reqValid = 0;
        while (rspValid !== 1'b1) @(negedge sys_clk);
    endtask : access
    task automatic t_lanes;
        access(DPS_OP_WRITE, 14'h3fff, 16'h1234, 2'b11, 1'b0);
        check({15'h0, mailFlag}, 16'h0001);
        access(DPS_OP_WRITE, 14'h3fff, 16'habcd, 2'b10, 1'b0);
        access(DPS_OP_READ, 14'h3fff, 16'h0000, 2'b11, 1'b0);
        check(rspRData, 16'hab34);
        access(DPS_OP_WRITE, 14'h3fff, 16'h99ef, 2'b01, 1'b1);
        access(DPS_OP_READ, 14'h3fff, 16'h0000, 2'b11, 1'b0);
        check(rspRData, 16'habef);
    endtask : t_lanes
    task automatic t_token;
        access(DPS_OP_TOKEN, 14'h0002, 16'h0000, 2'b11, 1'b0);
        check({15'h0, rspGranted}, 16'h0001);
        otherHold = 1;
        access(DPS_OP_TOKEN, 14'h0005, 16'h0000, 2'b11, 1'b0);
        check({15'h0, rspGranted}, 16'h0000);
    endtask : t_token
    task automatic t_busy;
        busyHold = 1;
        n = nWr;
        fork
            access(DPS_OP_WRITE, 14'h0007, 16'h5a5a, 2'b11, 1'b0);
            begin
                repeat (20) @(negedge sys_clk);
                check(16'(nWr - n), 16'h0000);
                busyHold = 0;
            end
        join
        access(DPS_OP_READ, 14'h0007, 16'h0000, 2'b11, 1'b0);
        check(rspRData, 16'h5a5a);
    endtask : t_busy
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            $display("MISMATCH %0t timeout", $time);
            report_and_stop;
        end
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        reset = 0;
        t_lanes;
        t_token;
        t_busy;
        report_and_stop;
    end
endmodule : dps_host_test
`default_nettype wire
